// File: src/dis_pkg.sv
package dis_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int MCLK_MHZ = 200;
    localparam int CAL_TIME_NS = 1000; // calibration_time, least
    // Least time, rounded up to whole mclk cycles
    localparam logic [7:0] CAL_CYC = 8'((CAL_TIME_NS * MCLK_MHZ + 999) / 1000);
    localparam logic [7:0] CNT_RESET = 8'h00;

    // ****************************************
    // Command encodings, first beat ca[4:0]
    // ****************************************
    localparam logic [4:0] CA_MRW1 = 5'h06;
    localparam logic [4:0] CA_MRW2 = 5'h16;
    localparam logic [4:0] CA_MPC = 5'h00;

    // Multipurpose opcodes
    localparam logic [6:0] MPC_ZQ_START = 7'h4f;
    localparam logic [6:0] MPC_ZQ_LATCH = 7'h51;
    localparam logic [6:0] MPC_FIFO_WR = 7'h47;
    localparam logic [6:0] MPC_FIFO_RD = 7'h41;
    localparam logic [6:0] MPC_RD_CAL = 7'h43;

    // ****************************************
    // Mode registers and fields
    // ****************************************
    localparam logic [5:0] MA_TWO = 6'h02;
    localparam logic [5:0] MA_CBT = 6'h0d;
    localparam int WLEV_BIT = 7;
    localparam int CBT_BIT = 0;
    localparam logic [7:0] MR_RESET = 8'h00;

    // ****************************************
    // Data path values
    // ****************************************
    localparam logic [7:0] DRV_CODE_RESET = 8'h00;
    localparam logic [7:0] CAL_CODE = 8'h5a;
    localparam logic [15:0] RD_CAL_PATTERN = 16'ha55a;
    localparam logic [15:0] DQ_RESET = 16'h0000;
    localparam logic [2:0] FIFO_LAST = 3'h4;
    localparam logic [2:0] PTR_RESET = 3'h0;

    typedef enum logic [1:0] {BT_IDLE, BT_MRW1, BT_MRW2, BT_MPC} dis_beat_t;

endpackage : dis_pkg

// File: src/dis_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dis_sync (
    input wire logic clk,
    input wire logic rstn,
    input wire logic d,
    output logic q
);
    logic meta_q;

    // Two stage level synchroniser
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : dis_sync
`default_nettype wire

// File: src/dis_seq.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Outputs stay high impedance while reset pin is low.
// - Latch at least 1 us after start applies calibrated codes.
// - Receivers start low speed until command bus training ends on a low clock gate.
// - In command bus training, command bus pattern returns on DQ.
// - Mode register two bit seven high enters write leveling.
// - FIFO write, read and read calibration train DQ, array untouched.
// - After DQ training the device accepts any valid command; ready here needs the latch and command bus training exit, not DQ training.
// - Outputs stay high impedance while clock gate is low.
module dis_seq
    import dis_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic link_ck,
    input wire logic clk_gate,
    input wire logic cs,
    input wire logic [5:0] cmd_addr_bus,
    input wire logic [15:0] dq_i,
    output logic [15:0] dq_o,
    output logic dq_oe,
    output logic dmi_o,
    output logic dmi_oe,
    output logic [7:0] drv_code,
    output logic low_speed_rx,
    output logic cbt_mode,
    output logic wlev_mode,
    output logic ready,
    output logic cal_busy
);
    // ****************************************
    // Link side capture
    // ****************************************
    logic gate_s;
    logic cs_q;
    logic [5:0] ca_q;
    logic [15:0] dqi_q;
    dis_beat_t beat_q;
    logic [5:0] ma_q;
    logic op7_q;
    logic op6_q;
    logic [7:0] mr_two_q;
    logic cbt_q;
    logic cal_tgl_q;
    logic cal_done_s;
    logic applied_q;
    logic low_speed_q;
    logic [15:0] fifo_q [0:4];
    logic [2:0] wptr_q;
    logic [2:0] rptr_q;
    logic [15:0] dq_q;
    logic drive_q;

    // Clock gate pin is asynchronous to the link clock
    dis_sync u_gate_sync (
        .clk(link_ck),
        .rstn(rstn),
        .d(clk_gate),
        .q(gate_s)
    );

    // Command bus sampled on the link clock
    always_ff @(posedge link_ck or negedge rstn) begin
        if (!rstn) begin
            cs_q <= 1'b0;
            ca_q <= 6'h00;
            dqi_q <= DQ_RESET;
        end else begin
            cs_q <= cs & gate_s;
            ca_q <= cmd_addr_bus;
            dqi_q <= dq_i;
        end
    end

    // ****************************************
    // Two beat command decode
    // ****************************************
    logic first_beat;
    logic mrw_done;
    logic mpc_done;
    logic [6:0] mpc_op;
    assign first_beat = cs_q && !cbt_q;
    assign mrw_done = (beat_q == BT_MRW2);
    assign mpc_done = (beat_q == BT_MPC);
    assign mpc_op = {op6_q, ca_q};

    // First beat selects the command, second carries its operand
    always_ff @(posedge link_ck or negedge rstn) begin
        if (!rstn) begin
            beat_q <= BT_IDLE;
            op7_q <= 1'b0;
            op6_q <= 1'b0;
        end else if (first_beat && ca_q[4:0] == CA_MRW1) begin
            beat_q <= BT_MRW1;
            op7_q <= ca_q[5];
        end else if (first_beat && ca_q[4:0] == CA_MRW2) begin
            beat_q <= BT_MRW2;
            op6_q <= ca_q[5];
        end else if (first_beat && ca_q[4:0] == CA_MPC) begin
            beat_q <= BT_MPC;
            op6_q <= ca_q[5];
        end else begin
            beat_q <= BT_IDLE;
        end
    end

    // Address of the pending mode write
    always_ff @(posedge link_ck or negedge rstn) begin
        if (!rstn) begin
            ma_q <= 6'h00;
        end else if (beat_q == BT_MRW1) begin
            ma_q <= ca_q;
        end
    end

    // ****************************************
    // Mode registers
    // ****************************************
    // Write leveling follows bit seven of mode register two
    always_ff @(posedge link_ck or negedge rstn) begin
        if (!rstn) begin
            mr_two_q <= MR_RESET;
        end else if (mrw_done && ma_q == MA_TWO) begin
            mr_two_q <= {op7_q, op6_q, ca_q};
        end
    end

    // Training mode entry by mode write, exit only when clock gate seen low in mode, as no command decodes in mode
    always_ff @(posedge link_ck or negedge rstn) begin
        if (!rstn) begin
            cbt_q <= 1'b0;
        end else if (mrw_done && ma_q == MA_CBT) begin
            cbt_q <= ca_q[CBT_BIT];
        end else if (cbt_q && !gate_s) begin
            cbt_q <= 1'b0;
        end
    end

    // Low speed receivers until training leaves on a low clock gate
    always_ff @(posedge link_ck or negedge rstn) begin
        if (!rstn) begin
            low_speed_q <= 1'b1;
        end else if (cbt_q && !(mrw_done && ma_q == MA_CBT && ca_q[CBT_BIT]) && !gate_s) begin
            low_speed_q <= 1'b0;
        end
    end

    // ****************************************
    // Impedance calibration
    // ****************************************
    // Start toggles an event across to mclk
    always_ff @(posedge link_ck or negedge rstn) begin
        if (!rstn) begin
            cal_tgl_q <= 1'b0;
        end else if (mpc_done && mpc_op == MPC_ZQ_START) begin
            cal_tgl_q <= ~cal_tgl_q;
        end
    end

    // Latch applies the result only once calibration has run its time
    always_ff @(posedge link_ck or negedge rstn) begin
        if (!rstn) begin
            drv_code <= DRV_CODE_RESET;
            applied_q <= 1'b0;
        end else if (mpc_done && mpc_op == MPC_ZQ_LATCH && cal_done_s) begin
            drv_code <= CAL_CODE;
            applied_q <= 1'b1;
        end
    end

    // ****************************************
    // DQ training FIFO, separate from the array
    // ****************************************
    // FIFO write stores DQ, pointer wraps at the last entry
    always_ff @(posedge link_ck or negedge rstn) begin
        if (!rstn) begin
            wptr_q <= PTR_RESET;
            for (int i = 0; i <= int'(FIFO_LAST); i++) begin
                fifo_q[i] <= DQ_RESET;
            end
        end else if (mpc_done && mpc_op == MPC_FIFO_WR) begin
            fifo_q[wptr_q] <= dqi_q;
            wptr_q <= (wptr_q == FIFO_LAST) ? PTR_RESET : wptr_q + 3'h1;
        end
    end

    // Read pointer of the training FIFO
    always_ff @(posedge link_ck or negedge rstn) begin
        if (!rstn) begin
            rptr_q <= PTR_RESET;
        end else if (mpc_done && mpc_op == MPC_FIFO_RD) begin
            rptr_q <= (rptr_q == FIFO_LAST) ? PTR_RESET : rptr_q + 3'h1;
        end
    end

    // ****************************************
    // Output drive
    // ****************************************
    // Pattern echo, FIFO read or read calibration; one cycle each
    always_ff @(posedge link_ck or negedge rstn) begin
        if (!rstn) begin
            dq_q <= DQ_RESET;
            drive_q <= 1'b0;
        end else if (!gate_s) begin
            drive_q <= 1'b0;
        end else if (cbt_q && cs_q) begin
            dq_q <= {10'h000, ca_q};
            drive_q <= 1'b1;
        end else if (mpc_done && mpc_op == MPC_FIFO_RD) begin
            dq_q <= fifo_q[rptr_q];
            drive_q <= 1'b1;
        end else if (mpc_done && mpc_op == MPC_RD_CAL) begin
            dq_q <= RD_CAL_PATTERN;
            drive_q <= 1'b1;
        end else begin
            drive_q <= 1'b0;
        end
    end

    // Enables fall with reset or a low clock gate
    assign dq_oe = drive_q && rstn;
    assign dmi_oe = 1'b0;
    assign dmi_o = 1'b0;
    assign dq_o = dq_q;
    assign low_speed_rx = low_speed_q;
    assign cbt_mode = cbt_q;
    assign wlev_mode = mr_two_q[WLEV_BIT];
    assign ready = applied_q && !cbt_q && !mr_two_q[WLEV_BIT] && !low_speed_q;

    // ****************************************
    // Calibration timer on mclk
    // ****************************************
    logic tgl_s;
    logic tgl_seen_q;
    logic [7:0] cnt_q;
    logic busy_q;
    logic done_q;

    // Start event arrives as a toggle
    dis_sync u_tgl_sync (
        .clk(mclk),
        .rstn(rstn),
        .d(cal_tgl_q),
        .q(tgl_s)
    );

    // Completion level goes back to the link side
    dis_sync u_done_sync (
        .clk(link_ck),
        .rstn(rstn),
        .d(done_q),
        .q(cal_done_s)
    );

    // Count calibration_time, a new start restarts the run
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tgl_seen_q <= 1'b0;
            cnt_q <= CNT_RESET;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (ce) begin
            tgl_seen_q <= tgl_s;
            if (tgl_s != tgl_seen_q) begin
                cnt_q <= CNT_RESET;
                busy_q <= 1'b1;
                done_q <= 1'b0;
            end else if (busy_q && cnt_q == CAL_CYC - 8'h01) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
            end else if (busy_q) begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    assign cal_busy = busy_q;

    // ****************************************
    // Checks
    // ****************************************
    logic [8:0] chk_cnt_q;

    // Enabled cycles since the run began
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            chk_cnt_q <= 9'h000;
        end else if (ce && tgl_s != tgl_seen_q) begin
            chk_cnt_q <= 9'h000;
        end else if (ce && busy_q) begin
            chk_cnt_q <= chk_cnt_q + 9'h001;
        end
    end

    hiz_reset_a: assert property (@(posedge mclk) !rstn |-> !dq_oe && !dmi_oe)
        else $error("outputs driven during reset");
    hiz_gate_a: assert property (@(posedge link_ck) disable iff (!rstn)
        !gate_s |=> !dq_oe)
        else $error("outputs driven with clock gate low");
    cal_time_a: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(done_q) |-> chk_cnt_q == {1'b0, CAL_CYC})
        else $error("calibration time wrong");
    latch_apply_a: assert property (@(posedge link_ck) disable iff (!rstn)
        $changed(drv_code) |-> drv_code == CAL_CODE && $past(cal_done_s))
        else $error("codes applied before calibration finished");
    low_speed_a: assert property (@(posedge link_ck) disable iff (!rstn)
        $fell(low_speed_rx) |-> $past(cbt_q))
        else $error("receivers left low speed outside training");
    cbt_echo_a: assert property (@(posedge link_ck) disable iff (!rstn)
        cbt_q && cs_q && gate_s ##1 gate_s |-> dq_oe && dq_o[5:0] == $past(ca_q))
        else $error("training pattern not returned");
    wlev_entry_a: assert property (@(posedge link_ck) disable iff (!rstn)
        mrw_done && ma_q == MA_TWO |=> wlev_mode == $past(op7_q))
        else $error("write leveling mode wrong");
    fifo_read_a: assert property (@(posedge link_ck) disable iff (!rstn)
        mpc_done && mpc_op == MPC_FIFO_RD && gate_s && !(cbt_q && cs_q)
        |=> dq_o == $past(fifo_q[rptr_q]))
        else $error("FIFO read data wrong");
    ready_gate_a: assert property (@(posedge link_ck) disable iff (!rstn)
        ready |-> drv_code == CAL_CODE && !cbt_mode && !wlev_mode && !low_speed_rx)
        else $error("ready during training");

    cal_run_c: cover property (@(posedge mclk) disable iff (!rstn) $rose(done_q));
    cbt_entry_c: cover property (@(posedge link_ck) disable iff (!rstn) $rose(cbt_q));
    ready_c: cover property (@(posedge link_ck) disable iff (!rstn) $rose(ready));

endmodule : dis_seq
`default_nettype wire

// File: test/dis_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Controller side of the link
// ****************************************
module dis_ctrl_model
    import dis_pkg::*;
#(
    parameter int GATE_LOW_CYC = 8,
    parameter int MODE_IDLE_CYC = 4
) (
    input wire logic link_ck,
    output logic clk_gate,
    output logic cs,
    output logic [5:0] cmd_addr_bus,
    output logic [15:0] dq_i
);
    // Gate low from power-up
    initial begin
        clk_gate = 1'b0;
        cs = 1'b0;
        cmd_addr_bus = 6'h15;
        dq_i = 16'h0f0f;
    end

    // Idle cycles, released lines flip every cycle
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge link_ck);
            cs = 1'b0;
            cmd_addr_bus = ~cmd_addr_bus;
            dq_i = ~dq_i;
        end
    endtask : idle

    // One chip-select beat
    task automatic beat(input logic [5:0] b);
        @(negedge link_ck);
        cs = 1'b1;
        cmd_addr_bus = b;
    endtask : beat

    // Two-beat command, write data on second beat
    task automatic cmd(input logic [5:0] b1, input logic [5:0] b2, input logic [15:0] wd);
        beat(b1);
        @(negedge link_ck);
        cs = 1'b0;
        cmd_addr_bus = b2;
        dq_i = wd;
    endtask : cmd

    // Mode write, halves back to back
    task automatic mode_write_cmd(input logic [5:0] ma, input logic [7:0] op);
        cmd({op[7], CA_MRW1}, ma, ~dq_i);
        cmd({op[6], CA_MRW2}, op[5:0], ~dq_i);
        idle(1);
    endtask : mode_write_cmd

    // Multipurpose command, two idle cycles after
    task automatic multipurpose_cmd(input logic [6:0] opc, input logic [15:0] wd);
        cmd({opc[6], CA_MPC}, opc[5:0], wd);
        idle(2);
    endtask : multipurpose_cmd

    // Drop the gate ahead of reset or power-off
    task automatic gate_low();
        @(negedge link_ck);
        clk_gate = 1'b0;
    endtask : gate_low

    // Waits in whole link cycles, then gate up with cs low
    task automatic bring_up();
        idle(GATE_LOW_CYC);
        clk_gate = 1'b1;
        idle(MODE_IDLE_CYC);
    endtask : bring_up
endmodule : dis_ctrl_model
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dis_pkg::*;
    logic mclk;
    logic link_ck;
    logic rstn;
    logic ce;
    logic clk_gate, cs, dq_oe, dmi_o, dmi_oe, low_speed_rx, cbt_mode, wlev_mode, ready, cal_busy;
    logic [5:0] ca;
    logic [15:0] dq_i, dq_o, got;
    logic [7:0] drv_code;
    int error_cnt = 0;
    int comparisons = 0;
    int busy_cnt = 0;

    // ****************************************
    // Clocks, link clock 64 ns, boot rate
    // ****************************************
    always #2.5 mclk = ~mclk;
    initial begin
        mclk = 1'b0;
        link_ck = 1'b0;
        rstn = 1'b0;
        ce = 1'b1;
        #0.7;
        forever #32 link_ck = ~link_ck;
    end
    // Random clock enable, counts enabled busy cycles
    always @(negedge mclk) ce <= ($urandom_range(3) != 0);
    always @(posedge mclk) if (cal_busy === 1'b1 && ce) busy_cnt++;

    dis_ctrl_model ctrl_u (.link_ck(link_ck), .clk_gate(clk_gate), .cs(cs),
        .cmd_addr_bus(ca), .dq_i(dq_i));
    dis_seq dut_u (.mclk(mclk), .rstn(rstn), .ce(ce), .link_ck(link_ck), .clk_gate(clk_gate),
        .cs(cs), .cmd_addr_bus(ca), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .dmi_o(dmi_o),
        .dmi_oe(dmi_oe), .drv_code(drv_code), .low_speed_rx(low_speed_rx),
        .cbt_mode(cbt_mode), .wlev_mode(wlev_mode), .ready(ready), .cal_busy(cal_busy));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Expected write leveling flag for a mode register two value
    function automatic logic exp_wlev(input logic [7:0] val);
        return val[WLEV_BIT];
    endfunction : exp_wlev

    // Wait for a one-cycle answer on the data bus
    task automatic wait_answer();
        int n;
        n = 0;
        while (dq_oe !== 1'b1 && n < 8) begin
            ctrl_u.idle(1);
            n++;
        end
        got = dq_o;
        check(dq_oe, 1'b1);
        ctrl_u.idle(1);
        check(dq_oe, 1'b0);
    endtask : wait_answer

    // Reset pulse with gate already low
    task automatic pulse_reset(input int cyc);
        ctrl_u.gate_low();
        @(negedge mclk);
        rstn = 1'b0;
        repeat (cyc) @(negedge mclk);
        check({dq_oe, dmi_oe, low_speed_rx, ready, cal_busy}, 16'h0004);
        check({drv_code, wlev_mode, cbt_mode}, 16'h0000);
        rstn = 1'b1;
    endtask : pulse_reset

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    initial begin
        #200000;
        error_cnt++;
        finish_test();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        logic [7:0] op;
        logic [15:0] wd [5];
        logic [5:0] b;
        int n;
        void'($urandom(32'h593a_dbda));
        pulse_reset(16);
        ctrl_u.mode_write_cmd(MA_TWO, 8'h80);
        ctrl_u.idle(3);
        check(wlev_mode, 1'b0);
        ctrl_u.bring_up();
        $display("Test reset and gate done");
        for (int i = 0; i < 4; i++) begin
            op = 8'($urandom());
            op[7] = ~i[0];
            ctrl_u.mode_write_cmd(MA_TWO, op);
            ctrl_u.idle(2);
            check(wlev_mode, exp_wlev(op));
            check(ready, 1'b0);
        end
        $display("Test write leveling done");
        ctrl_u.mode_write_cmd(6'h0b, 8'($urandom()));
        ctrl_u.multipurpose_cmd(MPC_ZQ_LATCH, 16'h1234);
        check(drv_code, DRV_CODE_RESET);
        busy_cnt = 0;
        ctrl_u.multipurpose_cmd(MPC_ZQ_START, 16'h4321);
        check(cal_busy, 1'b1);
        n = 0;
        while (cal_busy === 1'b1 && n < 60) begin
            ctrl_u.idle(1);
            n++;
        end
        check(cal_busy, 1'b0);
        check(16'(busy_cnt), 16'(CAL_CYC));
        ctrl_u.multipurpose_cmd(MPC_ZQ_LATCH, 16'h5678);
        check(drv_code, CAL_CODE);
        ctrl_u.idle(8);
        $display("Test calibration done");
        for (int i = 0; i < 5; i++) begin
            wd[i] = 16'($urandom());
            ctrl_u.multipurpose_cmd(MPC_FIFO_WR, wd[i]);
        end
        for (int i = 0; i < 5; i++) begin
            ctrl_u.multipurpose_cmd(MPC_FIFO_RD, 16'($urandom()));
            wait_answer();
            check(got, wd[i]);
        end
        ctrl_u.multipurpose_cmd(MPC_RD_CAL, 16'($urandom()));
        wait_answer();
        check(got, RD_CAL_PATTERN);
        check({dmi_o, dmi_oe}, 16'h0000);
        $display("Test fifo training done");
        ctrl_u.mode_write_cmd(MA_CBT, 8'h01);
        ctrl_u.idle(2);
        check(cbt_mode, 1'b1);
        for (int i = 0; i < 3; i++) begin
            b = 6'($urandom());
            ctrl_u.beat(b);
            wait_answer();
            check(got[5:0], b);
        end
        ctrl_u.gate_low();
        ctrl_u.idle(4);
        check({cbt_mode, low_speed_rx, dq_oe}, 16'h0000);
        ctrl_u.bring_up();
        check(ready, 1'b1);
        ctrl_u.mode_write_cmd(MA_TWO, 8'h80);
        ctrl_u.idle(2);
        check(wlev_mode, 1'b1);
        $display("Test command training done");
        pulse_reset(20);
        ctrl_u.bring_up();
        ctrl_u.mode_write_cmd(MA_TWO, 8'h80);
        ctrl_u.idle(2);
        check(wlev_mode, 1'b1);
        check(ready, 1'b0);
        $display("Test warm reset done");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
